//--- hdl/sms_regs.vh
/*
 * register offsets, field positions, reset values and sizes of the
 * mirror and aggregation egress selector.
 * assumes byte addresses on an 8-bit address port, 32-bit data words.
 */
`ifndef SMS_REGS_VH
`define SMS_REGS_VH

// ****************************************************************
// sizes
// ****************************************************************
`define SMS_NPORT      12
`define SMS_NGRP       5
`define SMS_MAXMEM     4'ha

// ****************************************************************
// register byte offsets; group blocks are codes of address bits 7:5
// ****************************************************************
`define SMS_A_MDEST    8'h00
`define SMS_A_MMODE    8'h04
`define SMS_A_HASH     8'h08
`define SMS_A_GTYPE    8'h0c
`define SMS_A_STAT     8'h10
`define SMS_A_GMEM     3'h1
`define SMS_A_GACT     3'h2
`define SMS_A_GLIM     3'h3

// ****************************************************************
// fields and codes
// ****************************************************************
`define SMS_MDEST_EN   4
`define SMS_HB_SMAC    0
`define SMS_HB_DMAC    1
`define SMS_HB_IP      2
`define SMS_HB_L4      3
`define SMS_MODE_DIS   2'h0
`define SMS_MODE_RX    2'h1
`define SMS_MODE_TX    2'h2
`define SMS_MODE_BOTH  2'h3

// ****************************************************************
// reset values
// ****************************************************************
`define SMS_RST_HASH   4'hd
`define SMS_RST_MDEST  5'h00
`define SMS_RST_MMODE  24'h000000
`define SMS_RST_GMEM   12'h000

`endif

//--- hdl/sms_hash.v
/*
 * flow hash for aggregation member choice.
 * purely combinational; fields come from the same clock domain.
 */
`include "sms_regs.vh"

module sms_hash (
    // contributor enables
    input  wire [3:0]  i_hash_en,
    // frame header fields
    input  wire [47:0] i_smac,
    input  wire [47:0] i_dmac,
    input  wire [31:0] i_sip,
    input  wire [31:0] i_dip,
    input  wire [15:0] i_sport,
    input  wire [15:0] i_dport,
    input  wire        i_is_ipv4,
    input  wire        i_is_l4,
    // hash result
    output wire [7:0]  o_hash
);

    // fold a 48-bit value to one byte by xor of its bytes
    function [7:0] fold8;
        input [47:0] v;
        integer k;
        begin
            fold8 = 8'h00;
            for (k = 0; k < 6; k = k + 1) begin
                fold8 = fold8 ^ v[k*8 +: 8];
            end
        end
    endfunction

    wire       use_ip;  // ip addresses contribute
    wire       use_l4;  // l4 ports contribute, ipv4 only
    wire [7:0] h_smac;  // per-field parts
    wire [7:0] h_dmac;
    wire [7:0] h_ip;
    wire [7:0] h_l4;

    assign use_ip = i_hash_en[`SMS_HB_IP] & i_is_ipv4;
    assign use_l4 = i_hash_en[`SMS_HB_L4] & i_is_ipv4 & i_is_l4;

    // each part depends only on its own fields, so a flow always hashes
    // the same and never spreads over members
    assign h_smac = i_hash_en[`SMS_HB_SMAC] ? fold8(i_smac) : 8'h00;
    assign h_dmac = i_hash_en[`SMS_HB_DMAC] ? fold8(i_dmac) : 8'h00;
    assign h_ip   = use_ip ? fold8({16'h0000, i_sip ^ i_dip}) : 8'h00;
    assign h_l4   = use_l4 ? fold8({32'h00000000, i_sport ^ i_dport})
                           : 8'h00;

    // rotate parts so equal fields do not cancel each other
    assign o_hash = h_smac ^ {h_dmac[5:0], h_dmac[7:6]}
                  ^ {h_ip[3:0], h_ip[7:4]} ^ {h_l4[1:0], h_l4[7:2]};

endmodule // sms_hash

//--- hdl/sms_egress_sel.v
/*
 * mirror and aggregation egress selector: per frame descriptor it
 * builds the egress port mask, adds the mirror copy and picks one
 * member of an aggregation group.
 * assumes link, duplex and speed status come from logic on i_ref_clk;
 * one descriptor per cycle at most; registers over a plain strobe port.
 */
// The implementer's own choices: the strobed register port and the register addresses.
//
// Contract
// - mirror copy added beside normal forwarding
// - one mirror destination; disabled stops all
// - rx-only copies received frames only
// - tx-only copies transmitted frames only
// - both copies received and transmitted frames
// - disabled port copies nothing
// - mirror destination only disabled or rx-only
// - group members full duplex, same speed
// - group forwarded as one logical port
// - port in at most one group
// - reject member as mirror source/destination
// - one flow always one member
// - hash from enabled mac, ip, l4 fields
// - up to ten members per group
// - at most five groups
// - negotiated group: extras standby, replace failures
// - static group: all members active
// - reset hash defaults, no group members
`include "sms_regs.vh"

module sms_egress_sel (
    // clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rst_b,
    // register port
    input  wire [7:0]  i_reg_addr,
    input  wire [31:0] i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output reg  [31:0] o_reg_rdata,
    // port status
    input  wire [11:0] i_link_up,
    input  wire [11:0] i_port_fdx,
    input  wire [23:0] i_port_speed,
    // frame descriptor in
    input  wire        i_frm_valid,
    input  wire [3:0]  i_frm_src,
    input  wire [3:0]  i_frm_dst,
    input  wire        i_frm_to_grp,
    input  wire [2:0]  i_frm_grp,
    input  wire [47:0] i_smac,
    input  wire [47:0] i_dmac,
    input  wire [31:0] i_sip,
    input  wire [31:0] i_dip,
    input  wire [15:0] i_sport,
    input  wire [15:0] i_dport,
    input  wire        i_is_ipv4,
    input  wire        i_is_l4,
    // egress decision out
    output reg         o_fwd_valid,
    output reg  [11:0] o_fwd_mask,
    output reg         o_fwd_mirror
);

    // ************************************************************
    // helper functions
    // ************************************************************

    // number of set bits in a port mask
    function [3:0] popcnt;
        input [11:0] m;
        integer k;
        begin
            popcnt = 4'h0;
            for (k = 0; k < `SMS_NPORT; k = k + 1) begin
                popcnt = popcnt + {3'h0, m[k]};
            end
        end
    endfunction

    // ports whose mode copies anything (mirror sources)
    function [11:0] src_mask;
        input [23:0] modes;
        integer k;
        begin
            src_mask = 12'h000;
            for (k = 0; k < `SMS_NPORT; k = k + 1) begin
                src_mask[k] = |modes[k*2 +: 2];
            end
        end
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    reg  [4:0]  mdest_reg;          // mirror port and enable
    reg  [23:0] mmode_reg;          // two mode bits per port
    reg  [3:0]  hash_en_reg;        // hash contributor enables
    reg  [4:0]  gtype_reg;          // 1 = negotiated group
    reg         rej_reg;            // sticky rejected write
    reg  [11:0] gmem_reg [0:4];     // configured members
    reg  [3:0]  glim_reg [0:4];     // negotiated active limit
    wire [11:0] gact [0:4];         // active members per group

    wire        mir_en;             // mirror enabled
    wire [3:0]  mir_port;           // mirror port number
    wire [2:0]  a_grp;              // group index of address
    wire [2:0]  a_blk;              // block of address
    wire        a_gok;              // group index in range
    reg  [11:0] all_mem;            // union of all groups
    reg  [11:0] oth_mem;            // union of other groups
    reg         wr_ok;              // write passes checks
    reg         spd_ok;             // member speeds agree
    reg  [1:0]  spd_ref;            // speed of first member
    reg         spd_set;            // first member seen
    integer     g;
    integer     p;
    integer     r;
    assign mir_en   = mdest_reg[`SMS_MDEST_EN];
    assign mir_port = mdest_reg[3:0];
    assign a_blk    = i_reg_addr[7:5];
    assign a_grp    = i_reg_addr[4:2];
    assign a_gok    = (a_grp < `SMS_NGRP) && (i_reg_addr[1:0] == 2'h0);

    // ************************************************************
    // write checks
    // ************************************************************

    // a bad configuration is dropped whole and flags the status bit,
    // so the live tables never hold a half-applied illegal state
    always @* begin
        all_mem = 12'h000;
        oth_mem = 12'h000;
        spd_ok  = 1'b1;
        spd_ref = 2'h0;
        spd_set = 1'b0;
        for (g = 0; g < `SMS_NGRP; g = g + 1) begin
            all_mem = all_mem | gmem_reg[g];
            if (g != a_grp) begin
                oth_mem = oth_mem | gmem_reg[g];
            end
        end
        // all new members must share one speed
        for (p = 0; p < `SMS_NPORT; p = p + 1) begin
            if (i_reg_wdata[p]) begin
                if (spd_set && (i_port_speed[p*2 +: 2] != spd_ref)) begin
                    spd_ok = 1'b0;
                end
                spd_ref = spd_set ? spd_ref : i_port_speed[p*2 +: 2];
                spd_set = 1'b1;
            end
        end
        wr_ok = 1'b1;
        if (i_reg_addr == `SMS_A_MDEST) begin
            // destination may not be a member nor copy its own tx
            if (i_reg_wdata[`SMS_MDEST_EN] &&
                (all_mem[i_reg_wdata[3:0]] ||
                 mmode_reg[{i_reg_wdata[3:0], 1'b1}] ||
                 (i_reg_wdata[3:0] >= `SMS_NPORT))) begin
                wr_ok = 1'b0;
            end
        end else if (i_reg_addr == `SMS_A_MMODE) begin
            if ((src_mask(i_reg_wdata[23:0]) & all_mem) != 12'h000) begin
                wr_ok = 1'b0;
            end
            if (mir_en && i_reg_wdata[{mir_port, 1'b1}]) begin
                wr_ok = 1'b0;
            end
        end else if ((a_blk == `SMS_A_GMEM) && a_gok) begin
            if (popcnt(i_reg_wdata[11:0]) > `SMS_MAXMEM) begin
                wr_ok = 1'b0;
            end
            if ((i_reg_wdata[11:0] & ~i_port_fdx) != 12'h000) begin
                wr_ok = 1'b0;
            end
            if (!spd_ok) begin
                wr_ok = 1'b0;
            end
            if ((i_reg_wdata[11:0] & oth_mem) != 12'h000) begin
                wr_ok = 1'b0;
            end
            if (((i_reg_wdata[11:0] & src_mask(mmode_reg)) != 12'h000) ||
                (mir_en && i_reg_wdata[mir_port])) begin
                wr_ok = 1'b0;
            end
        end
    end

    // ************************************************************
    // register writes
    // ************************************************************

    // five group slots only; addresses past them are ignored
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            mdest_reg   <= `SMS_RST_MDEST;
            mmode_reg   <= `SMS_RST_MMODE;
            hash_en_reg <= `SMS_RST_HASH;
            gtype_reg   <= 5'h00;
            rej_reg     <= 1'b0;
            for (r = 0; r < `SMS_NGRP; r = r + 1) begin
                gmem_reg[r] <= `SMS_RST_GMEM;
                glim_reg[r] <= 4'h0;
            end
        end else if (i_reg_wr) begin
            if (!wr_ok) begin
                rej_reg <= 1'b1;
            end else if (i_reg_addr == `SMS_A_MDEST) begin
                mdest_reg <= i_reg_wdata[4:0];
            end else if (i_reg_addr == `SMS_A_MMODE) begin
                mmode_reg <= i_reg_wdata[23:0];
            end else if (i_reg_addr == `SMS_A_HASH) begin
                hash_en_reg <= i_reg_wdata[3:0];
            end else if (i_reg_addr == `SMS_A_GTYPE) begin
                gtype_reg <= i_reg_wdata[4:0];
            end else if (i_reg_addr == `SMS_A_STAT) begin
                // write one clears; only a rejection sets it
                rej_reg <= rej_reg & ~i_reg_wdata[0];
            end else if ((a_blk == `SMS_A_GMEM) && a_gok) begin
                gmem_reg[a_grp] <= i_reg_wdata[11:0];
            end else if ((a_blk == `SMS_A_GLIM) && a_gok) begin
                glim_reg[a_grp] <= i_reg_wdata[3:0];
            end
        end
    end

    // ************************************************************
    // register reads
    // ************************************************************

    // data stands for one cycle only; unmapped offsets read zero
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 32'h00000000;
        end else if (!i_reg_rd) begin
            o_reg_rdata <= 32'h00000000;
        end else if (i_reg_addr == `SMS_A_MDEST) begin
            o_reg_rdata <= {27'h0000000, mdest_reg};
        end else if (i_reg_addr == `SMS_A_MMODE) begin
            o_reg_rdata <= {8'h00, mmode_reg};
        end else if (i_reg_addr == `SMS_A_HASH) begin
            o_reg_rdata <= {28'h0000000, hash_en_reg};
        end else if (i_reg_addr == `SMS_A_GTYPE) begin
            o_reg_rdata <= {27'h0000000, gtype_reg};
        end else if (i_reg_addr == `SMS_A_STAT) begin
            o_reg_rdata <= {31'h00000000, rej_reg};
        end else if ((a_blk == `SMS_A_GMEM) && a_gok) begin
            o_reg_rdata <= {20'h00000, gmem_reg[a_grp]};
        end else if ((a_blk == `SMS_A_GACT) && a_gok) begin
            o_reg_rdata <= {20'h00000, gact[a_grp]};
        end else if ((a_blk == `SMS_A_GLIM) && a_gok) begin
            o_reg_rdata <= {28'h0000000, glim_reg[a_grp]};
        end else begin
            o_reg_rdata <= 32'h00000000;
        end
    end

    // ************************************************************
    // active member sets
    // ************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < `SMS_NGRP; gi = gi + 1) begin : g_act
            reg [11:0] act;     // chosen active members
            reg [3:0]  lim;     // active limit in force
            reg [3:0]  cnt;     // members taken so far
            integer    q;
            // in a negotiated group the lowest-numbered live members fill the active set; a
            // failed link drops out and the next standby takes over; a static group keeps all members
            always @* begin
                act = 12'h000;
                cnt = 4'h0;
                lim = (glim_reg[gi] == 4'h0) ? `SMS_MAXMEM : glim_reg[gi];
                for (q = 0; q < `SMS_NPORT; q = q + 1) begin
                    if (gmem_reg[gi][q] && i_link_up[q] && (cnt < lim)) begin
                        act[q] = 1'b1;
                        cnt = cnt + 4'h1;
                    end
                end
                if (!gtype_reg[gi]) begin
                    act = gmem_reg[gi];
                end
            end
            assign gact[gi] = act;
        end
    endgenerate

    // ************************************************************
    // member choice
    // ************************************************************
    wire [7:0]  hash;       // flow hash of this frame
    wire [11:0] cand;       // active members of target group
    wire [3:0]  n_act;      // their count
    wire [7:0]  pick;       // index among active members
    reg  [11:0] one_hot;    // chosen member port
    reg  [3:0]  seen;       // active members passed
    reg  [11:0] egress;     // normal egress mask
    reg         mir_hit;    // copy goes to mirror port
    integer     m;
    integer     n;
    sms_hash u_hash (
        .i_hash_en (hash_en_reg),
        .i_smac    (i_smac),
        .i_dmac    (i_dmac),
        .i_sip     (i_sip),
        .i_dip     (i_dip),
        .i_sport   (i_sport),
        .i_dport   (i_dport),
        .i_is_ipv4 (i_is_ipv4),
        .i_is_l4   (i_is_l4),
        .o_hash    (hash)
    );

    assign cand  = (i_frm_grp < `SMS_NGRP) ? gact[i_frm_grp] : 12'h000;
    assign n_act = popcnt(cand);
    // an empty group divides by one and then finds no member
    assign pick  = hash % ((n_act == 4'h0) ? 8'h01 : {4'h0, n_act});

    // walk to the pick-th active member; exactly one bit survives unless the group is empty
    always @* begin
        one_hot = 12'h000;
        seen    = 4'h0;
        for (m = 0; m < `SMS_NPORT; m = m + 1) begin
            if (cand[m]) begin
                if (seen == pick) begin
                    one_hot[m] = 1'b1;
                end
                seen = seen + 4'h1;
            end
        end
    end

    // group looks like any single port to the forwarding path
    always @* begin
        egress  = 12'h000;
        mir_hit = 1'b0;
        if (i_frm_to_grp) begin
            egress = one_hot;
        end else if (i_frm_dst < `SMS_NPORT) begin
            egress[i_frm_dst] = 1'b1;
        end
        // rx side: mode rx-only or both on the source port
        if (i_frm_src < `SMS_NPORT) begin
            mir_hit = mmode_reg[{i_frm_src, 1'b0}];
        end
        // tx side: mode tx-only or both on any egress port
        for (n = 0; n < `SMS_NPORT; n = n + 1) begin
            if (egress[n] && mmode_reg[n*2 + 1]) begin
                mir_hit = 1'b1;
            end
        end
        mir_hit = mir_hit & mir_en;
    end

    // ************************************************************
    // decision output
    // ************************************************************

    // one register stage; the copy is added, the frame still goes out
    always @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_fwd_valid  <= 1'b0;
            o_fwd_mask   <= 12'h000;
            o_fwd_mirror <= 1'b0;
        end else begin
            o_fwd_valid  <= i_frm_valid;
            o_fwd_mirror <= i_frm_valid & mir_hit;
            if (i_frm_valid && mir_hit) begin
                o_fwd_mask <= egress | (12'h001 << mir_port);
            end else if (i_frm_valid) begin
                o_fwd_mask <= egress;
            end else begin
                o_fwd_mask <= 12'h000;
            end
        end
    end

endmodule // sms_egress_sel

//--- verification/sms_far_end.sv
/*
 * far end model: link partner ports seen by the egress selector.
 * assumes the bench steers link, duplex and speed per port.
 */
module sms_far_end (
    // clock
    input  wire logic        i_clk,
    // per port faults commanded by the bench
    input  wire logic [11:0] i_down,
    input  wire logic [11:0] i_half,
    input  wire logic [11:0] i_slow,
    // port status toward the selector
    output logic      [11:0] o_link_up,
    output logic      [11:0] o_fdx,
    output logic      [23:0] o_speed
);
    timeunit 1ns;
    timeprecision 1ps;
    // status follows the command one clock later
    always @(posedge i_clk) begin
        o_link_up <= ~i_down;
        o_fdx     <= ~i_half;
        for (int p = 0; p < 12; p++) begin
            o_speed[2*p +: 2] <= i_slow[p] ? 2'h1 : 2'h2;
        end
    end
endmodule // sms_far_end

//--- verification/sms_egress_sel_monitor.sv
/*
 * checker: frame path timing and egress mask shape of the selector.
 * assumes one clock and the bind at the foot of this file.
 */
module sms_egress_mon (
    // clock and reset
    input logic        i_ref_clk,
    input logic        i_rst_b,
    // strobes and frame fields
    input logic        i_reg_wr,
    input logic        i_reg_rd,
    input logic        i_frm_valid,
    input logic [3:0]  i_frm_src,
    input logic [3:0]  i_frm_dst,
    input logic        i_frm_to_grp,
    input logic [2:0]  i_frm_grp,
    input logic [47:0] i_smac,
    input logic [47:0] i_dmac,
    input logic [31:0] i_sip,
    input logic [31:0] i_dip,
    input logic [15:0] i_sport,
    input logic [15:0] i_dport,
    input logic        i_is_ipv4,
    input logic        i_is_l4,
    input logic [11:0] i_link_up,
    // outputs watched
    input logic [31:0] o_reg_rdata,
    input logic        o_fwd_valid,
    input logic [11:0] o_fwd_mask,
    input logic        o_fwd_mirror
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // flow key: equal keys must pick equal ports
    wire  [205:0] key = {i_smac, i_dmac, i_sip, i_dip, i_sport, i_dport,
        i_is_ipv4, i_is_l4, i_frm_src, i_frm_dst, i_frm_to_grp, i_frm_grp};
    a_rst_quiet: assert property (disable iff (1'b0)
        !i_rst_b |=> !o_fwd_valid && o_reg_rdata == 32'h0)
        else $error("outputs not quiet after reset");
    a_fwd_latency: assert property (i_frm_valid |=> o_fwd_valid)
        else $error("decision missing one cycle after frame");
    a_no_spurious: assert property (!i_frm_valid |=> !o_fwd_valid)
        else $error("decision without a frame");
    a_idle_mask: assert property (!o_fwd_valid |->
        o_fwd_mask == 12'h0 && !o_fwd_mirror)
        else $error("mask or mirror set while idle");
    a_dst_kept: assert property (o_fwd_valid && !$past(i_frm_to_grp) &&
        $past(i_frm_dst) < 4'hc |-> o_fwd_mask[$past(i_frm_dst)])
        else $error("normal egress port lost");
    a_plain_exact: assert property (o_fwd_valid && !o_fwd_mirror &&
        !$past(i_frm_to_grp) && $past(i_frm_dst) < 4'hc |->
        o_fwd_mask == 12'h1 << $past(i_frm_dst))
        else $error("extra port without mirror copy");
    a_grp_single: assert property (o_fwd_valid && !o_fwd_mirror &&
        $past(i_frm_to_grp) |-> $onehot0(o_fwd_mask))
        else $error("group frame on several members");
    a_grp_range: assert property (o_fwd_valid && !o_fwd_mirror &&
        $past(i_frm_to_grp) && $past(i_frm_grp) > 3'h4 |->
        o_fwd_mask == 12'h0)
        else $error("egress for a group that does not exist");
    a_mirror_port: assert property (o_fwd_mirror |-> o_fwd_mask != 0)
        else $error("mirror flag without a port");
    a_flow_stable: assert property (i_frm_valid && $stable(key) &&
        $past(i_frm_valid) && !$past(i_reg_wr) && $stable(i_link_up)
        |=> $stable(o_fwd_mask)) else $error("same flow changed member");

    c_mirror: cover property (o_fwd_valid && o_fwd_mirror);
    c_group: cover property (i_frm_valid && i_frm_to_grp ##1 o_fwd_valid);
    c_read: cover property (i_reg_wr ##1 i_reg_rd);
endmodule // sms_egress_mon

bind sms_egress_sel sms_egress_mon u_mon (.*);

//--- verification/sms_egress_sel_tb.sv
/*
 * bench for the egress selector: register tasks, frame tasks, tests.
 * assumes the far end model drives port status; one 25 MHz clock.
 */
`include "sms_regs.vh"
module sms_egress_sel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk = 1'b0, i_rst_b = 1'b0;
    logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_frm_valid = 1'b0;
    logic        i_frm_to_grp = 1'b0, i_is_ipv4 = 1'b1, i_is_l4 = 1'b1;
    logic [7:0]  i_reg_addr = 8'h0;
    logic [31:0] i_reg_wdata = 32'h0, i_sip = 32'h0a000001;
    logic [31:0] i_dip = 32'h0a000002;
    logic [3:0]  i_frm_src = 4'h0, i_frm_dst = 4'h0;
    logic [2:0]  i_frm_grp = 3'h0;
    logic [47:0] i_smac = 48'h02a1b2c3d4e5, i_dmac = 48'h02f0e1d2c3b4;
    logic [15:0] i_sport = 16'h1f90, i_dport = 16'h0050;
    logic [11:0] down = 12'h0, half = 12'h0, slow = 12'h0, seen, keep;
    wire  [31:0] o_reg_rdata;
    wire  [11:0] o_fwd_mask, link_up, fdx;
    wire  [23:0] speed;
    wire         o_fwd_valid, o_fwd_mirror;
    int          n_mismatch = 0, comparisons = 0;

    always #20 i_ref_clk = ~i_ref_clk;

    sms_egress_sel uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
        .i_link_up(link_up), .i_port_fdx(fdx), .i_port_speed(speed),
        .i_frm_valid(i_frm_valid), .i_frm_src(i_frm_src),
        .i_frm_dst(i_frm_dst), .i_frm_to_grp(i_frm_to_grp),
        .i_frm_grp(i_frm_grp), .i_smac(i_smac), .i_dmac(i_dmac),
        .i_sip(i_sip), .i_dip(i_dip), .i_sport(i_sport), .i_dport(i_dport),
        .i_is_ipv4(i_is_ipv4), .i_is_l4(i_is_l4), .o_fwd_valid(o_fwd_valid),
        .o_fwd_mask(o_fwd_mask), .o_fwd_mirror(o_fwd_mirror));
    sms_far_end u_far (.i_clk(i_ref_clk), .i_down(down), .i_half(half),
        .i_slow(slow), .o_link_up(link_up), .o_fdx(fdx), .o_speed(speed));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    // one-cycle write strobe, then released
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_ref_clk);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_reg_rd <= 1'b0;
        #1 chk(o_reg_rdata, e);
    endtask
    // n frames back to back; mask 12'hfff: caller checks
    task automatic frm(input int n, input logic [3:0] s, input logic [3:0] d,
        input logic tg, input logic [2:0] g, input logic [11:0] e);
        @(posedge i_ref_clk);
        i_frm_src <= s;
        i_frm_dst <= d;
        i_frm_to_grp <= tg;
        i_frm_grp <= g;
        i_frm_valid <= 1'b1;
        for (int k = 0; k < n; k++) begin
            @(posedge i_ref_clk);
            if (k == n - 1) i_frm_valid <= 1'b0;
            #1 seen = o_fwd_mask;
            chk({31'h0, o_fwd_valid}, 32'h1);
            if (e !== 12'hfff) chk({19'h0, o_fwd_mirror, seen},
                {19'h0, e[11], e});
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        rd(`SMS_A_HASH, 32'hd);
        rd(8'h20, 32'h0);
        rd(`SMS_A_MDEST, 32'h0);
        rd(8'h14, 32'h0);
        $display("test reset finished");
        wr(8'h28, 32'hffe);  // eleven members must be refused
        rd(8'h28, 32'h0);
        rd(`SMS_A_STAT, 32'h1);
        wr(`SMS_A_STAT, 32'h1);
        wr(8'h28, 32'h7fe);
        rd(8'h28, 32'h7fe);
        wr(8'h28, 32'h0);
        $display("test size finished");
        half = 12'h080;
        wr(8'h24, 32'h0c0);
        rd(8'h24, 32'h0);
        half = 12'h0;
        slow = 12'h040;
        wr(8'h24, 32'h0c0);
        rd(8'h24, 32'h0);
        slow = 12'h0;
        wr(`SMS_A_STAT, 32'h1);
        wr(8'h20, 32'h030);
        wr(8'h24, 32'h010);
        rd(8'h24, 32'h0);
        rd(8'h20, 32'h030);
        wr(`SMS_A_STAT, 32'h1);
        $display("test membership finished");
        wr(`SMS_A_MDEST, 32'h1b);
        for (int m = 0; m < 4; m++) begin
            wr(`SMS_A_MMODE, m);
            frm(1, 4'h0, 4'h1, 1'b0, 3'h0, m[0] ? 12'h802 : 12'h002);
            frm(1, 4'h2, 4'h0, 1'b0, 3'h0, m[1] ? 12'h801 : 12'h001);
        end
        wr(8'h24, 32'h001);
        rd(8'h24, 32'h0);
        rd(`SMS_A_STAT, 32'h1);
        wr(`SMS_A_STAT, 32'h1);
        wr(`SMS_A_MDEST, 32'h14);
        rd(`SMS_A_MDEST, 32'h1b);
        wr(`SMS_A_MMODE, 32'h800003);
        rd(`SMS_A_MMODE, 32'h3);
        rd(`SMS_A_STAT, 32'h1);
        wr(`SMS_A_STAT, 32'h1);
        wr(`SMS_A_MDEST, 32'h0b);
        frm(1, 4'h0, 4'h1, 1'b0, 3'h0, 12'h002);
        $display("test mirror finished");
        wr(`SMS_A_MMODE, 32'h0);
        wr(`SMS_A_HASH, 32'h0);
        frm(1, 4'h0, 4'h0, 1'b1, 3'h0, 12'h010);
        rd(8'h40, 32'h030);
        wr(`SMS_A_HASH, 32'hf);
        frm(2, 4'h3, 4'h0, 1'b1, 3'h0, 12'hfff);
        chk({31'h0, seen == 12'h010 || seen == 12'h020}, 32'h1);
        wr(`SMS_A_HASH, 32'h1);
        frm(1, 4'h3, 4'h0, 1'b1, 3'h0, 12'hfff);
        keep = seen;
        i_dmac <= i_dmac ^ 48'h40;
        frm(1, 4'h3, 4'h0, 1'b1, 3'h0, keep);
        wr(`SMS_A_GTYPE, 32'h1);
        wr(8'h60, 32'h1);
        rd(8'h40, 32'h010);
        down = 12'h010;
        rd(8'h40, 32'h020);
        frm(1, 4'h0, 4'h0, 1'b1, 3'h0, 12'h020);
        frm(1, 4'h0, 4'h0, 1'b1, 3'h5, 12'h000);
        frm(1, 4'h0, 4'h0, 1'b1, 3'h3, 12'h000);
        $display("test aggregation finished");
        close_out();
    end
endmodule // sms_egress_sel_tb
